// file: design/enm_event_notify.sv
// Event notification and multidrop polling address logic of the field device
`timescale 1ns/100ps
module enm_event_notify (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Status inputs from device diagnostics (other clock domain)
    input  wire logic [enm_pkg::ENM_ALL_W-1:0] status_in,
    input  wire logic        cfg_change,
    // Link side
    output logic             notify_send,
    output logic             notify_is_event,
    output logic             multidrop,
    output logic             loop_fixed,
    output logic             alarm_en,
    output logic             irq
);
    import enm_pkg::*;

    // Synchronisers for asynchronous status inputs
    logic [ENM_ALL_W-1:0] st_s1_reg, st_s2_reg;
    logic                 cc_s1_reg, cc_s2_reg, cc_d_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_s1_reg <= '0;
            st_s2_reg <= '0;
            cc_s1_reg <= 1'b0;
            cc_s2_reg <= 1'b0;
            cc_d_reg  <= 1'b0;
        end else begin
            st_s1_reg <= status_in;
            st_s2_reg <= st_s1_reg;
            cc_s1_reg <= cfg_change;
            cc_s2_reg <= cc_s1_reg;
            cc_d_reg  <= cc_s2_reg;
        end
    end
    wire logic cc_pulse = cc_s2_reg & ~cc_d_reg;   // One pulse per change

    // Software registers
    logic             ctrl_en_reg;                 // Monitoring enable
    logic [11:0]      timing_reg;                  // Retry, max update, debounce codes
    logic [ENM_ALL_W-1:0] mask_reg;                // 1 = bit may raise events
    logic [7:0]       cfg_cnt_reg;                 // Configuration change counter
    logic             cfg_flag_reg;                // Configuration changed flag
    logic [5:0]       poll_reg;                    // Polling address
    logic [2:0]       irq_stat_reg, irq_en_reg;    // New event, ack, send

    // Period code lookup, used for both timers
    function automatic logic [12:0] enm_period(input logic [3:0] code);
        case (code)
            4'h0: enm_period = ENM_P0;
            4'h1: enm_period = ENM_P1;
            4'h2: enm_period = ENM_P2;
            4'h3: enm_period = ENM_P3;
            4'h4: enm_period = ENM_P4;
            4'h5: enm_period = ENM_P5;
            4'h6: enm_period = ENM_P6;
            4'h7: enm_period = ENM_P7;
            4'h8: enm_period = ENM_P8;
            4'h9: enm_period = ENM_P9;
            4'hA: enm_period = ENM_P10;
            4'hB: enm_period = ENM_P11;
            4'hC: enm_period = ENM_P12;
            default: enm_period = ENM_P13;
        endcase
    endfunction

    // Full status vector with the configuration flag merged in
    logic [ENM_ALL_W-1:0] status_full;
    always_comb begin
        status_full = st_s2_reg;
        status_full[ENM_CFG_CHG_BIT] = cfg_flag_reg;
    end
    // Only unmasked bits count; the counter bypasses the mask
    wire logic [ENM_ALL_W-1:0] watched = status_full & mask_reg;

    // Half-second timebase
    logic [ENM_CNT_W-1:0] tb_reg;
    logic                 tick_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tb_reg   <= '0;
            tick_reg <= 1'b0;
        end else if (tb_reg == ENM_CNT_W'(ENM_TICK_CYC - 1)) begin
            tb_reg   <= '0;
            tick_reg <= 1'b1;
        end else begin
            tb_reg   <= tb_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // Debounce: a change must persist for the debounce interval
    logic [ENM_ALL_W-1:0] cand_reg, last_reg;
    logic                 deb_run_reg;
    logic                 deb_exp;
    wire logic deb_off = (timing_reg[ENM_TIM_DEB_LSB +: 4] == 4'h0);
    wire logic changed = (watched != last_reg);
    enm_period_timer u_deb (
        .clk     (clk),
        .arst_n  (arst_n),
        .tick    (tick_reg),
        .restart (!deb_run_reg || (watched != cand_reg)),
        .limit   (enm_period(timing_reg[ENM_TIM_DEB_LSB +: 4] - 4'h1)),
        .expired (deb_exp)
    );
    // Qualified event: settled status change or a counter step
    wire logic settle = deb_off ? changed : (deb_run_reg && deb_exp && (cand_reg == watched));
    wire logic new_event = ctrl_en_reg && (settle || cc_pulse);

    // Track candidate and last reported status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cand_reg    <= '0;
            last_reg    <= '0;
            deb_run_reg <= 1'b0;
        end else begin
            cand_reg    <= watched;
            deb_run_reg <= changed && !settle;
            if (settle) begin
                last_reg <= watched;
            end
        end
    end

    // Event history: four records of number and status snapshot
    logic [7:0]           num_reg;                 // Latest event number
    logic [ENM_STAT_W-1:0] hist_lo_reg [ENM_HIST_N];
    logic [7:0]           hist_st_reg [ENM_HIST_N]; // Event status byte, 0 once acked
    logic [1:0]           wptr_reg;
    logic                 ack_hit;
    logic [1:0]           ack_idx;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            num_reg  <= 8'h00;
            wptr_reg <= 2'h0;
            for (int i = 0; i < ENM_HIST_N; i++) begin
                hist_lo_reg[i] <= '0;
                hist_st_reg[i] <= 8'h00;
            end
        end else begin
            if (ack_hit) begin
                hist_st_reg[ack_idx] <= 8'h00;
            end
            if (new_event) begin
                num_reg <= num_reg + 8'h01;
                wptr_reg <= wptr_reg + 2'h1;     // Oldest slot is overwritten
                hist_lo_reg[wptr_reg] <= status_full[ENM_STAT_W-1:0];
                hist_st_reg[wptr_reg] <= 8'h01;  // Set beats a same-cycle ack
            end
        end
    end

    // Look up a requested event number among the four kept
    function automatic logic [2:0] enm_find(input logic [7:0] req, input logic [7:0] latest,
                                            input logic [1:0] wp);
        logic [7:0] age;
        age = latest - req;
        if (latest != 8'h00 && age < 8'h04) begin
            enm_find = {1'b1, wp - 2'h1 - age[1:0]};
        end else begin
            enm_find = 3'b000;
        end
    endfunction

    // Host transactions: read event (0) and acknowledge (1)
    logic [31:0] txn_res_reg;      // Number, status, hit flag
    logic [1:0]  sel_reg;          // Slot chosen by the last read or acknowledge
    wire logic   txn_wr = reg_wr && (reg_addr == ENM_OFF_TXN);
    wire logic [7:0] txn_num = (reg_wdata[7:0] == 8'h00) ? num_reg : reg_wdata[7:0];
    wire logic [2:0] found = enm_find(txn_num, num_reg, wptr_reg);
    assign ack_hit = txn_wr && (reg_wdata[9:8] == ENM_TXN_ACK) && found[2];
    assign ack_idx = found[1:0];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txn_res_reg <= 32'h0000_0000;
            sel_reg     <= 2'h0;
        end else if (txn_wr) begin
            sel_reg     <= found[1:0];
            txn_res_reg <= {15'h0000, found[2], ack_hit ? 8'h00 : hist_st_reg[found[1:0]],
                            txn_num};
        end
    end
    // Only the latest event keeps the notifier busy, so acking it ends the repeats
    wire logic any_pending = (hist_st_reg[wptr_reg - 2'h1] != 8'h00);

    // Notifier state and retry or update timing
    enm_state_e state_reg;
    logic       per_exp;
    wire logic [3:0] per_code = (state_reg == ENM_PENDING) ? timing_reg[ENM_TIM_RETRY_LSB +: 4]
                                                        : timing_reg[ENM_TIM_MAXUPD_LSB +: 4];
    enm_period_timer u_per (
        .clk     (clk),
        .arst_n  (arst_n),
        .tick    (tick_reg),
        .restart (state_reg == ENM_IDLE || new_event || ack_hit),
        .limit   (enm_period(per_code)),
        .expired (per_exp)
    );
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg       <= ENM_IDLE;
            notify_send     <= 1'b0;
            notify_is_event <= 1'b0;
        end else begin
            notify_send     <= 1'b0;
            notify_is_event <= 1'b0;
            case (state_reg)
                ENM_IDLE: begin
                    if (ctrl_en_reg) begin
                        state_reg <= ENM_MONITOR;
                    end
                end
                ENM_MONITOR: begin
                    if (!ctrl_en_reg) begin
                        state_reg <= ENM_IDLE;
                    end else if (new_event || any_pending) begin
                        state_reg       <= ENM_PENDING;
                        notify_send     <= 1'b1;
                        notify_is_event <= 1'b1;
                    end else if (per_exp) begin
                        notify_send <= 1'b1;
                    end
                end
                ENM_PENDING: begin
                    if (!ctrl_en_reg) begin
                        state_reg <= ENM_IDLE;
                    end else if (!any_pending) begin
                        state_reg <= ENM_MONITOR;
                    end else if (per_exp) begin
                        notify_send     <= 1'b1;
                        notify_is_event <= 1'b1;
                    end
                end
                default: state_reg <= ENM_IDLE;
            endcase
        end
    end

    // Multidrop outputs follow the polling address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            multidrop  <= 1'b0;
            loop_fixed <= 1'b0;
            alarm_en   <= 1'b1;
        end else begin
            multidrop  <= (poll_reg != 6'h00) && (poll_reg <= ENM_POLL_MAX);
            loop_fixed <= (poll_reg != 6'h00);
            alarm_en   <= (poll_reg == 6'h00);
        end
    end

    // Configuration writes, change counter and flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_en_reg  <= 1'b0;
            timing_reg   <= 12'h000;
            mask_reg     <= '0;
            poll_reg     <= 6'h00;
            cfg_cnt_reg  <= 8'h00;
            cfg_flag_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == ENM_OFF_CTRL) begin
                ctrl_en_reg <= reg_wdata[ENM_CTRL_EN_BIT];
            end else if (reg_wr && reg_addr == ENM_OFF_TIMING) begin
                timing_reg <= reg_wdata[11:0];
            end else if (reg_wr && reg_addr == ENM_OFF_MASK_LO) begin
                mask_reg[31:0] <= reg_wdata;
            end else if (reg_wr && reg_addr == ENM_OFF_MASK_HI) begin
                mask_reg[63:32] <= reg_wdata;
            end else if (reg_wr && reg_addr == ENM_OFF_MASK_2) begin
                mask_reg[95:64] <= reg_wdata;
            end else if (reg_wr && reg_addr == ENM_OFF_MASK_3) begin
                mask_reg[ENM_ALL_W-1:96] <= reg_wdata[ENM_ALL_W-97:0];
            end else if (reg_wr && reg_addr == ENM_OFF_POLL) begin
                poll_reg <= reg_wdata[5:0];
            end
            if (cc_pulse) begin
                cfg_cnt_reg  <= cfg_cnt_reg + 8'h01;
                cfg_flag_reg <= 1'b1;
            end else if (reg_wr && reg_addr == ENM_OFF_CFG_CHG && reg_wdata[ENM_CFG_CHG_BIT]) begin
                cfg_flag_reg <= 1'b0;                  // Set wins over clear
            end
        end
    end

    // Interrupt status: new event, acknowledge, notification sent
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_reg <= 3'h0;
            irq_en_reg   <= 3'h0;
            irq          <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == ENM_OFF_IRQ_EN) begin
                irq_en_reg <= reg_wdata[2:0];
            end
            irq_stat_reg <= (irq_stat_reg & ~((reg_wr && reg_addr == ENM_OFF_IRQ_CLR)
                            ? reg_wdata[2:0] : 3'h0)) | {notify_send, ack_hit, new_event};
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == ENM_OFF_CTRL) begin
            reg_rdata <= {29'h0, state_reg, ctrl_en_reg};
        end else if (reg_addr == ENM_OFF_TIMING) begin
            reg_rdata <= {20'h0, timing_reg};
        end else if (reg_addr == ENM_OFF_MASK_LO) begin
            reg_rdata <= mask_reg[31:0];
        end else if (reg_addr == ENM_OFF_MASK_HI) begin
            reg_rdata <= mask_reg[63:32];
        end else if (reg_addr == ENM_OFF_MASK_2) begin
            reg_rdata <= mask_reg[95:64];
        end else if (reg_addr == ENM_OFF_MASK_3) begin
            reg_rdata <= {14'h0000, mask_reg[ENM_ALL_W-1:96]};
        end else if (reg_addr == ENM_OFF_STAT_LO) begin
            reg_rdata <= status_full[31:0];
        end else if (reg_addr == ENM_OFF_STAT_HI) begin
            reg_rdata <= status_full[63:32];
        end else if (reg_addr == ENM_OFF_CFG_CHG) begin
            reg_rdata <= {23'h0, cfg_flag_reg, cfg_cnt_reg};
        end else if (reg_addr == ENM_OFF_TXN_RES) begin
            reg_rdata <= txn_res_reg;
        end else if (reg_addr == ENM_OFF_NOTIFY) begin
            reg_rdata <= {23'h0, any_pending, num_reg};
        end else if (reg_addr == ENM_OFF_IRQ_STAT) begin
            reg_rdata <= {29'h0, irq_stat_reg};
        end else if (reg_addr == ENM_OFF_IRQ_EN) begin
            reg_rdata <= {29'h0, irq_en_reg};
        end else if (reg_addr == ENM_OFF_POLL) begin
            reg_rdata <= {26'h0, poll_reg};
        end else if (reg_addr == ENM_OFF_SNAP_LO) begin
            reg_rdata <= hist_lo_reg[sel_reg][31:0];
        end else if (reg_addr == ENM_OFF_SNAP_HI) begin
            reg_rdata <= hist_lo_reg[sel_reg][63:32];
        end else begin
            reg_rdata <= 32'h0000_0000;      // Unmapped reads as zero
        end
    end

    // Assertions
    AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!arst_n)
        ack_hit && !new_event |=> hist_st_reg[$past(ack_idx)] == 8'h00)
        else $error("acknowledged event status not cleared");
    AST_NUM_STEP: assert property (@(posedge clk) disable iff (!arst_n)
        new_event |=> num_reg == $past(num_reg) + 8'h01)
        else $error("event number did not step by one");
    AST_CC_EVENT: assert property (@(posedge clk) disable iff (!arst_n)
        cc_pulse && ctrl_en_reg |=> num_reg == $past(num_reg) + 8'h01)
        else $error("configuration counter change raised no event");
    AST_CC_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
        cc_pulse |=> cfg_flag_reg && cfg_cnt_reg == $past(cfg_cnt_reg) + 8'h01)
        else $error("configuration change not recorded");
    AST_MDROP: assert property (@(posedge clk) disable iff (!arst_n)
        poll_reg inside {[6'h01:6'h0F]} |=> multidrop && loop_fixed && !alarm_en)
        else $error("multidrop outputs wrong");
    AST_P2P: assert property (@(posedge clk) disable iff (!arst_n)
        poll_reg == 6'h00 |=> !multidrop && !loop_fixed)
        else $error("address zero left multidrop active");
    AST_OFF_SILENT: assert property (@(posedge clk) disable iff (!arst_n)
        !ctrl_en_reg [*2] |=> !notify_send)
        else $error("notification sent while monitoring is off");
    AST_ACK_STOPS: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ENM_PENDING && !any_pending && !new_event |=> state_reg != ENM_PENDING)
        else $error("notification kept after acknowledge");
    AST_LATEST: assert property (@(posedge clk) disable iff (!arst_n)
        txn_wr && reg_wdata[7:0] == 8'h00 |=> txn_res_reg[7:0] == $past(num_reg))
        else $error("read of event zero did not return latest");
endmodule

// file: design/enm_period_timer.sv
// Period timer counting 0.5 s ticks up to a coded period
`timescale 1ns/100ps
module enm_period_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control
    input  wire logic        tick,
    input  wire logic        restart,
    input  wire logic [12:0] limit,
    // Result
    output logic             expired
);
    import enm_pkg::*;

    logic [12:0] cnt_reg;   // Ticks elapsed since restart

    // Count ticks, pulse expired on reaching the limit and wrap
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 13'h0000;
            expired <= 1'b0;
        end else if (restart) begin
            cnt_reg <= 13'h0000;
            expired <= 1'b0;
        end else if (tick && (cnt_reg + 13'h0001 >= limit)) begin
            cnt_reg <= 13'h0000;
            expired <= 1'b1;
        end else begin
            cnt_reg <= tick ? cnt_reg + 13'h0001 : cnt_reg;
            expired <= 1'b0;
        end
    end
endmodule

// file: design/enm_pkg.sv
// Package of constants and types for the event notification and multidrop block
package enm_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] ENM_OFF_CTRL      = 8'h00;
    localparam logic [7:0] ENM_OFF_TIMING    = 8'h04;
    localparam logic [7:0] ENM_OFF_MASK_LO   = 8'h08;
    localparam logic [7:0] ENM_OFF_MASK_HI   = 8'h0C;
    localparam logic [7:0] ENM_OFF_STAT_LO   = 8'h10;
    localparam logic [7:0] ENM_OFF_STAT_HI   = 8'h14;
    localparam logic [7:0] ENM_OFF_CFG_CHG   = 8'h18;
    localparam logic [7:0] ENM_OFF_TXN       = 8'h1C;
    localparam logic [7:0] ENM_OFF_TXN_RES   = 8'h20;
    localparam logic [7:0] ENM_OFF_NOTIFY    = 8'h24;
    localparam logic [7:0] ENM_OFF_IRQ_STAT  = 8'h28;
    localparam logic [7:0] ENM_OFF_IRQ_EN    = 8'h2C;
    localparam logic [7:0] ENM_OFF_IRQ_CLR   = 8'h30;
    localparam logic [7:0] ENM_OFF_POLL      = 8'h34;
    localparam logic [7:0] ENM_OFF_SNAP_LO   = 8'h38;
    localparam logic [7:0] ENM_OFF_SNAP_HI   = 8'h3C;
    localparam logic [7:0] ENM_OFF_MASK_2    = 8'h40;   // Mask bits 95:64
    localparam logic [7:0] ENM_OFF_MASK_3    = 8'h44;   // Mask bits 113:96, flags at 17:16

    // Status vector: 114 bits; word 0 and word 1 layouts
    localparam int ENM_STAT_W      = 64;
    localparam int ENM_DEVSTAT_LSB = 0;          // Device status byte
    localparam int ENM_CFG_CHG_BIT = 6;          // Configuration changed, 0x40
    localparam logic [7:0] ENM_CFG_CHG_MASK = 8'h40;
    localparam int ENM_GRP_LSB     = 8;          // Status groups 1..10, bytes 1..10
    localparam int ENM_GRP_N       = 10;
    localparam int ENM_EXT_LSB     = 88;         // Extended device status
    localparam int ENM_DIAG0_LSB   = 96;
    localparam int ENM_DIAG1_LSB   = 104;
    localparam int ENM_AO_SAT_BIT  = 112;        // analog_output_saturation_flag
    localparam int ENM_AO_PIN_BIT  = 113;        // analog_output_pinned_flag
    localparam int ENM_ALL_W       = 114;

    // Control and timing register fields
    localparam int ENM_CTRL_EN_BIT = 0;          // Monitoring enabled
    localparam int ENM_TIM_RETRY_LSB = 0;        // Retry period code, 4 bits
    localparam int ENM_TIM_MAXUPD_LSB = 4;       // Maximum update period code
    localparam int ENM_TIM_DEB_LSB = 8;          // Debounce code, 0 = off

    // Transaction codes
    localparam logic [1:0] ENM_TXN_READ = 2'h0;
    localparam logic [1:0] ENM_TXN_ACK  = 2'h1;

    // Event history
    localparam int ENM_HIST_N = 4;

    // Multidrop
    localparam logic [5:0] ENM_POLL_MAX = 6'h0F;
    localparam logic [15:0] ENM_LOOP_4MA = 16'h0FA0;   // 4 mA in microamps

    // Timebase: 20 MHz clock, 0.5 s tick
    localparam int ENM_CLK_HZ      = 20000000;
    localparam int ENM_TICK_MS     = 500;
    localparam int ENM_TICK_CYC    = ENM_CLK_HZ / 1000 * ENM_TICK_MS;
    localparam int ENM_CNT_W       = 24;

    // Period code to count of 0.5 s ticks: 0.5,1,2,4,8,16,32 s, 1,5,10,15,30,45,60 min
    localparam logic [12:0] ENM_P0  = 13'h0001;
    localparam logic [12:0] ENM_P1  = 13'h0002;
    localparam logic [12:0] ENM_P2  = 13'h0004;
    localparam logic [12:0] ENM_P3  = 13'h0008;
    localparam logic [12:0] ENM_P4  = 13'h0010;
    localparam logic [12:0] ENM_P5  = 13'h0020;
    localparam logic [12:0] ENM_P6  = 13'h0040;
    localparam logic [12:0] ENM_P7  = 13'h0078;
    localparam logic [12:0] ENM_P8  = 13'h0258;
    localparam logic [12:0] ENM_P9  = 13'h04B0;
    localparam logic [12:0] ENM_P10 = 13'h0708;
    localparam logic [12:0] ENM_P11 = 13'h0E10;
    localparam logic [12:0] ENM_P12 = 13'h1518;
    localparam logic [12:0] ENM_P13 = 13'h1C20;

    // Notifier states
    typedef enum logic [1:0] {
        ENM_IDLE    = 2'b00,
        ENM_MONITOR = 2'b01,
        ENM_PENDING = 2'b10
    } enm_state_e;
endpackage

// file: tb/enm_host_model.sv
// Host model counting the notifications seen on the link side
`timescale 1ns/100ps
module enm_host_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Link side of the device
    input  wire logic       notify_send,
    input  wire logic       notify_is_event,
    // Counts for the bench
    output logic [7:0]      sent_cnt,
    output logic [7:0]      event_cnt
);
    // One count per pulse; event notifications also step event_cnt
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sent_cnt  <= 8'h00;
            event_cnt <= 8'h00;
        end else if (notify_send) begin
            sent_cnt  <= sent_cnt + 8'h01;
            event_cnt <= event_cnt + {7'h00, notify_is_event};
        end
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the event notification block
`timescale 1ns/100ps
module testbench;
    import enm_pkg::*;
    logic        clk, arst_n, reg_wr, reg_rd, cfg_change, ns, ne, md, lf, ae, irq;
    logic [7:0]  reg_addr, sent_cnt, event_cnt, num, n0;
    logic [31:0] reg_wdata, reg_rdata, v;
    int          fails, tests_run, cyc;
    logic [ENM_ALL_W-1:0] st;   // Status levels seen by the device
    enm_event_notify u_enm_event_notify (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .status_in(st), .cfg_change, .notify_send(ns), .notify_is_event(ne),
        .multidrop(md), .loop_fixed(lf), .alarm_en(ae), .irq);
    enm_host_model u_enm_host_model (.clk, .arst_n, .notify_send(ns), .notify_is_event(ne),
        .sent_cnt, .event_cnt);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard: the run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // One configuration change, then the expected rise of the event count
    task automatic cfg_event(input logic [7:0] inc);
        num = event_cnt;
        @(posedge clk);
        cfg_change <= 1'b1;
        repeat (4) @(posedge clk);
        cfg_change <= 1'b0;
        repeat (20) @(posedge clk);
        chk({24'h0, event_cnt}, {24'h0, num + inc});
    endtask
    task automatic test_multidrop();
        logic [5:0] pa [3] = '{6'h01, 6'h0F, 6'h00};
        foreach (pa[i]) begin
            wr(ENM_OFF_POLL, {26'h0, pa[i]});
            repeat (2) @(posedge clk);
            #1 chk({29'h0, md, lf, ae}, (pa[i] != 6'h00) ? 32'h6 : 32'h1);
        end
        $display("test multidrop done");
    endtask
    task automatic test_events();
        wr(ENM_OFF_CTRL, 32'h1);
        wr(ENM_OFF_TIMING, 32'h10);
        wr(ENM_OFF_MASK_LO, 32'h0);
        wr(ENM_OFF_IRQ_EN, 32'h1);
        cfg_event(8'h01);
        rd(ENM_OFF_NOTIFY, v);
        n0 = v[7:0];
        chk({31'h0, v[8] & irq}, 32'h1);
        // A second event while one is pending waits for the retry period
        cfg_event(8'h00);
        rd(ENM_OFF_CFG_CHG, v);
        chk(v, 32'h102);
        wr(ENM_OFF_TXN, 32'h0);
        rd(ENM_OFF_TXN_RES, v);
        chk(v, {15'h0, 1'b1, 8'h01, n0 + 8'h01});
        wr(ENM_OFF_TXN, {22'h0, 2'b01, n0 + 8'h01});
        rd(ENM_OFF_TXN_RES, v);
        chk(v, {15'h0, 1'b1, 8'h00, n0 + 8'h01});
        rd(ENM_OFF_NOTIFY, v);
        chk({23'h0, v[8:0]}, {23'h0, 1'b0, n0 + 8'h01});
        wr(ENM_OFF_TXN, {24'h0, n0});
        rd(ENM_OFF_TXN_RES, v);
        chk({v[16], v[7:0]}, {1'b1, n0});
        wr(ENM_OFF_IRQ_CLR, 32'h7);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0);
        wr(ENM_OFF_CTRL, 32'h0);
        cfg_event(8'h00);
        rd(8'hFC, v);
        chk(v, 32'h0);
        $display("test events done");
    endtask
    // Masked status bits stay silent; unmasking one in the top or low word records an event
    task automatic test_mask();
        wr(ENM_OFF_CTRL, 32'h1);
        rd(ENM_OFF_NOTIFY, v);
        num = v[7:0];
        @(posedge clk);
        st <= ENM_ALL_W'(1) << ENM_AO_SAT_BIT | ENM_ALL_W'(1) << ENM_GRP_LSB;
        repeat (6) @(posedge clk);
        rd(ENM_OFF_NOTIFY, v);
        chk({24'h0, v[7:0]}, {24'h0, num});
        wr(ENM_OFF_MASK_3, 32'h0001_0000);
        rd(ENM_OFF_NOTIFY, v);
        chk({24'h0, v[7:0]}, {24'h0, num + 8'h01});
        wr(ENM_OFF_MASK_LO, 32'h0000_0100);
        rd(ENM_OFF_NOTIFY, v);
        chk({24'h0, v[7:0]}, {24'h0, num + 8'h02});
        $display("test mask done");
    endtask
    // Outputs right after reset release: only the alarm current is enabled
    task automatic test_reset();
        @(posedge clk);
        #1 chk({28'h0, md, lf, ae, irq}, 32'h2);
        $display("test reset done");
    endtask
    initial begin
        {arst_n, reg_wr, reg_rd, cfg_change, reg_addr, reg_wdata, st} = '0;
        {fails, tests_run, cyc} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        test_reset();
        test_multidrop();
        test_events();
        test_mask();
        print_verdict();
    end
endmodule
